/* smc_cfg.svh */
// Constants for the standby mode controller
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

`define SMC_ENTRY_DELAY      3'h4
`define SMC_CNT_ONE          3'h1
`define SMC_CNT_ZERO         3'h0
`define SMC_LVL_WAKE         2'h3
`define SMC_MODE_SUBCLK      2'h1
`define SMC_MODE_SUBCR       2'h0
`define SMC_MODE_MAINCR      2'h2
`define SMC_MODE_MAIN        2'h3
`define SMC_BIT_MAIN         1

`endif

/* smc_pkg.sv */
// Types for the standby mode controller
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_RESET_WAIT = 3'b000,
        SMC_RUN        = 3'b001,
        SMC_SLEEP      = 3'b010,
        SMC_STOP       = 3'b011,
        SMC_TIMER      = 3'b100,
        SMC_WATCH      = 3'b101,
        SMC_OSC_WAIT   = 3'b110
    } smc_state_t;

    typedef enum logic [1:0] {
        SMC_REQ_NONE  = 2'b00,
        SMC_REQ_SLEEP = 2'b01,
        SMC_REQ_STOP  = 2'b10,
        SMC_REQ_WATCH = 2'b11
    } smc_req_t;
endpackage : smc_pkg

/* smc_wake_detect.sv */
// Wake and entry-suppression detector for pending interrupt requests
`timescale 1ns/1ps
module smc_wake_detect (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  irq_pending,
    input  wire logic [15:0] irq_level,
    input  wire logic        ext_irq,
    output logic             high_irq_ff,
    output logic             ext_irq_ff
);
    `include "smc_cfg.svh"

    typedef struct packed {
        logic high_irq;
        logic ext_irq;
    } smc_wd_st_t;

    smc_wd_st_t st_ff;
    smc_wd_st_t nxt_st;

    // A request counts only if its level is at or above the wake level
    function automatic logic smc_any_high(input logic [7:0] pend, input logic [15:0] lvl);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (pend[i] && (lvl[2*i +: 2] >= `SMC_LVL_WAKE)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : smc_any_high

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.high_irq = smc_any_high(irq_pending, irq_level) | ext_irq;
        nxt_st.ext_irq  = ext_irq;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign high_irq_ff = st_ff.high_irq;
    assign ext_irq_ff  = st_ff.ext_irq;
endmodule : smc_wake_detect

/* standby_mode_controller.sv */
// Standby mode controller: entry, wake and pin state in low-power modes
// Notes on behaviour
// - Four standby states entered from request bits
// - Interrupt or reset ends standby, oscillator wait
// - Reset wake resumes in main CR mode
// - Interrupt wake keeps prior clock mode
// - Pin bit selects hold or float deep
// - Zero holds pins, one floats them
// - No entry while high-level or external interrupt pending
// - Pending high interrupt discards request permanently
// - Suppression ignores CPU interrupt masks
// - Entry four cycles after the write
// - Instruction in progress suspended, then resumed
// - High-level interrupt wakes sleep, timer-only and watch regardless of masks
// - Service if accepted else continue next
// - Reset waits both CR stabilization times
// - Sleep bit enters sleep, interrupt ends
// - Sleep stops CPU and watchdog clocks
// - Standby watchdog keeps sub-CR running
// - Stop bit enters stop, external wake
// - Watch bit in main modes gives timer-only
// - Watch bit in sub modes gives watch
// - Monitor field selects timer-only or watch
// - Stop halts main oscillator, sub-CR unless standby watchdog; external logic stays
`timescale 1ns/1ps
module standby_mode_controller (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        sleep_request_wr,
    input  wire logic        stop_request_wr,
    input  wire logic        watch_request_wr,
    input  wire logic        pin_hold_select,
    input  wire logic [1:0]  clock_mode_monitor,
    input  wire logic [7:0]  irq_pending,
    input  wire logic [15:0] irq_level,
    input  wire logic        ext_irq,
    input  wire logic        interrupt_enable_flag,
    input  wire logic [1:0]  interrupt_level_mask,
    input  wire logic [1:0]  accepted_irq_level,
    input  wire logic        instr_busy,
    input  wire logic        nvr_wdt_standby_en,
    input  wire logic        maincr_stable,
    input  wire logic        subcr_stable,
    input  wire logic        osc_stable,
    output logic             sleep_request,
    output logic             stop_request,
    output logic             watch_request,
    output logic             cpu_clk_en,
    output logic             wdt_clk_en,
    output logic             periph_clk_en,
    output logic             main_osc_en,
    output logic             subcr_osc_en,
    output logic             hw_wdt_run,
    output logic             pin_hold,
    output logic             pin_float,
    output logic             force_maincr,
    output logic             restore_clk_mode,
    output logic [1:0]       saved_clk_mode,
    output logic             instr_suspended,
    output logic             irq_service,
    output logic             in_standby
);
    `include "smc_cfg.svh"

    typedef struct packed {
        smc_pkg::smc_state_t state;
        smc_pkg::smc_req_t   req;
        logic [2:0]          cnt;
        logic                sleep_rq;
        logic                stop_rq;
        logic                watch_rq;
        logic [1:0]          mode;
        logic                reset_wake;
        logic                suspended;
        logic                service;
        logic                cpu_en;
        logic                wdt_en;
        logic                per_en;
        logic                mosc_en;
        logic                scr_en;
        logic                wdt_run;
        logic                hold;
        logic                flt;
        logic                force_cr;
        logic                restore;
        logic                stby;
    } smc_st_t;

    smc_st_t st_ff;
    smc_st_t nxt_st;
    logic    high_irq_ff;
    logic    ext_irq_ff;

    smc_wake_detect u_wake (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .irq_pending (irq_pending),
        .irq_level   (irq_level),
        .ext_irq     (ext_irq),
        .high_irq_ff (high_irq_ff),
        .ext_irq_ff  (ext_irq_ff)
    );

    // Deep states are stop, timer-only and watch
    function automatic logic smc_is_deep(input smc_pkg::smc_state_t s);
        return (s == smc_pkg::SMC_STOP) || (s == smc_pkg::SMC_TIMER) ||
               (s == smc_pkg::SMC_WATCH);
    endfunction : smc_is_deep

    // CPU accepts the interrupt when enabled and level beats the mask
    function automatic logic smc_cpu_accepts(input logic ie, input logic [1:0] msk,
                                             input logic [1:0] lvl);
        return ie && (lvl < msk);
    endfunction : smc_cpu_accepts

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.restore  = 1'b0;
        nxt_st.service  = 1'b0;
        nxt_st.force_cr = 1'b0;
        unique case (st_ff.state)
            smc_pkg::SMC_RESET_WAIT: begin
                nxt_st.force_cr = 1'b1;
                if (maincr_stable && subcr_stable) begin
                    nxt_st.state  = smc_pkg::SMC_RUN;
                    nxt_st.cpu_en = 1'b1;
                    nxt_st.wdt_en = 1'b1;
                end
            end
            smc_pkg::SMC_RUN: begin
                if (st_ff.req == smc_pkg::SMC_REQ_NONE) begin
                    if (sleep_request_wr || stop_request_wr || watch_request_wr) begin
                        if (high_irq_ff) begin
                            nxt_st.req = smc_pkg::SMC_REQ_NONE;
                        end else begin
                            nxt_st.cnt      = `SMC_ENTRY_DELAY - `SMC_CNT_ONE;
                            nxt_st.sleep_rq = sleep_request_wr;
                            nxt_st.stop_rq  = stop_request_wr;
                            nxt_st.watch_rq = watch_request_wr;
                            nxt_st.mode     = clock_mode_monitor;
                            if (stop_request_wr) begin
                                nxt_st.req = smc_pkg::SMC_REQ_STOP;
                            end else if (watch_request_wr) begin
                                nxt_st.req = smc_pkg::SMC_REQ_WATCH;
                            end else begin
                                nxt_st.req = smc_pkg::SMC_REQ_SLEEP;
                            end
                        end
                    end
                end else if (high_irq_ff) begin
                    nxt_st.req      = smc_pkg::SMC_REQ_NONE;
                    nxt_st.sleep_rq = 1'b0;
                    nxt_st.stop_rq  = 1'b0;
                    nxt_st.watch_rq = 1'b0;
                end else if (st_ff.cnt != `SMC_CNT_ONE) begin
                    nxt_st.cnt = st_ff.cnt - `SMC_CNT_ONE;
                end else begin
                    nxt_st.req       = smc_pkg::SMC_REQ_NONE;
                    nxt_st.cnt       = `SMC_CNT_ZERO;
                    nxt_st.stby      = 1'b1;
                    nxt_st.cpu_en    = 1'b0;
                    nxt_st.wdt_en    = 1'b0;
                    nxt_st.suspended = instr_busy;
                    nxt_st.wdt_run   = nvr_wdt_standby_en;
                    nxt_st.scr_en    = nvr_wdt_standby_en;
                    unique case (st_ff.req)
                        smc_pkg::SMC_REQ_SLEEP: begin
                            nxt_st.state  = smc_pkg::SMC_SLEEP;
                            nxt_st.per_en = 1'b1;
                        end
                        smc_pkg::SMC_REQ_STOP: begin
                            nxt_st.state   = smc_pkg::SMC_STOP;
                            nxt_st.per_en  = 1'b0;
                            nxt_st.mosc_en = 1'b0;
                        end
                        default: begin
                            nxt_st.per_en = 1'b0;
                            if (st_ff.mode[`SMC_BIT_MAIN]) begin
                                nxt_st.state = smc_pkg::SMC_TIMER;
                            end else begin
                                nxt_st.state   = smc_pkg::SMC_WATCH;
                                nxt_st.mosc_en = 1'b0;
                            end
                        end
                    endcase
                    nxt_st.hold = (st_ff.req != smc_pkg::SMC_REQ_SLEEP) && !pin_hold_select;
                    nxt_st.flt  = (st_ff.req != smc_pkg::SMC_REQ_SLEEP) && pin_hold_select;
                end
            end
            smc_pkg::SMC_SLEEP, smc_pkg::SMC_TIMER, smc_pkg::SMC_WATCH: begin
                if (high_irq_ff) begin
                    nxt_st.state = smc_pkg::SMC_OSC_WAIT;
                end
            end
            smc_pkg::SMC_STOP: begin
                if (ext_irq_ff) begin
                    nxt_st.state   = smc_pkg::SMC_OSC_WAIT;
                    nxt_st.mosc_en = 1'b1;
                end
            end
            smc_pkg::SMC_OSC_WAIT: begin
                nxt_st.mosc_en = 1'b1;
                if (osc_stable) begin
                    nxt_st.state     = smc_pkg::SMC_RUN;
                    nxt_st.stby      = 1'b0;
                    nxt_st.cpu_en    = 1'b1;
                    nxt_st.wdt_en    = 1'b1;
                    nxt_st.per_en    = 1'b1;
                    nxt_st.scr_en    = 1'b1;
                    nxt_st.wdt_run   = 1'b0;
                    nxt_st.hold      = 1'b0;
                    nxt_st.flt       = 1'b0;
                    nxt_st.restore   = 1'b1;
                    nxt_st.suspended = 1'b0;
                    nxt_st.sleep_rq  = 1'b0;
                    nxt_st.stop_rq   = 1'b0;
                    nxt_st.watch_rq  = 1'b0;
                    nxt_st.service   = smc_cpu_accepts(interrupt_enable_flag,
                                           interrupt_level_mask, accepted_irq_level);
                end
            end
            default: begin
                nxt_st.state = smc_pkg::SMC_RESET_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st_ff          <= '0;
            st_ff.state    <= smc_pkg::SMC_RESET_WAIT;
            st_ff.per_en   <= 1'b1;
            st_ff.mosc_en  <= 1'b1;
            st_ff.scr_en   <= 1'b1;
            st_ff.force_cr <= 1'b1;
            st_ff.mode     <= `SMC_MODE_MAINCR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sleep_request    = st_ff.sleep_rq;
    assign stop_request     = st_ff.stop_rq;
    assign watch_request    = st_ff.watch_rq;
    assign cpu_clk_en       = st_ff.cpu_en;
    assign wdt_clk_en       = st_ff.wdt_en;
    assign periph_clk_en    = st_ff.per_en;
    assign main_osc_en      = st_ff.mosc_en;
    assign subcr_osc_en     = st_ff.scr_en;
    assign hw_wdt_run       = st_ff.wdt_run;
    assign pin_hold         = st_ff.hold;
    assign pin_float        = st_ff.flt;
    assign force_maincr     = st_ff.force_cr;
    assign restore_clk_mode = st_ff.restore;
    assign saved_clk_mode   = st_ff.mode;
    assign instr_suspended  = st_ff.suspended;
    assign irq_service      = st_ff.service;
    assign in_standby       = st_ff.stby;

    // ==========================================================
    // Checks
    sequence s_req_taken;
        st_ff.state == smc_pkg::SMC_RUN && st_ff.req == smc_pkg::SMC_REQ_NONE &&
        (sleep_request_wr || stop_request_wr || watch_request_wr) && !high_irq_ff;
    endsequence

    a_entry_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_req_taken ##1 !high_irq_ff [*3] |=> in_standby)
        else $error("standby not entered four cycles after request");
    a_entry_early: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_req_taken |=> !in_standby [*3])
        else $error("standby entered too early");
    a_suppress_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_ff.state == smc_pkg::SMC_RUN && st_ff.req == smc_pkg::SMC_REQ_NONE &&
         sleep_request_wr && high_irq_ff) |=> !in_standby [*5])
        else $error("request not discarded under pending interrupt");
    a_watch_select: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(in_standby) && $past(st_ff.req) == smc_pkg::SMC_REQ_WATCH |->
        (st_ff.state == smc_pkg::SMC_TIMER) == st_ff.mode[`SMC_BIT_MAIN])
        else $error("wrong timer-only or watch choice");
    a_pin_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
        smc_is_deep(st_ff.state) |-> (pin_float != pin_hold))
        else $error("pin state not set in deep standby");
    a_sleep_clk: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.state == smc_pkg::SMC_SLEEP |-> !cpu_clk_en && !wdt_clk_en && periph_clk_en)
        else $error("sleep clock gating wrong");
    a_wake_irq: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (st_ff.state == smc_pkg::SMC_SLEEP && high_irq_ff) |=>
        st_ff.state == smc_pkg::SMC_OSC_WAIT)
        else $error("interrupt did not wake sleep");
    a_req_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(restore_clk_mode) |-> !sleep_request && !stop_request && !watch_request)
        else $error("request bits not cleared on wake");
    a_reset_cr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.state == smc_pkg::SMC_RESET_WAIT && !(maincr_stable && subcr_stable) |=>
        !cpu_clk_en)
        else $error("CPU ran before both CR clocks were stable");
endmodule : standby_mode_controller

/* smc_far_model.sv */
// Clock controller model: stabilisation flags for the standby controller
`timescale 1ns/1ps
module smc_far_model #(
    parameter int OSC_WAIT   = 12,
    parameter int MAINCR_WAIT = 20,
    parameter int SUBCR_WAIT = 30
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic main_osc_en,
    output logic      maincr_stable,
    output logic      subcr_stable,
    output logic      osc_stable
);
    int cnt_osc_ff;
    int cnt_rst_ff;

    // Reset runs both CR stabilisation waits, a stopped oscillator restarts its own
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_osc_ff <= 0;
            cnt_rst_ff <= 0;
        end else begin
            if (!main_osc_en)
                cnt_osc_ff <= 0;
            else if (cnt_osc_ff < OSC_WAIT)
                cnt_osc_ff <= cnt_osc_ff + 1;
            if (cnt_rst_ff < SUBCR_WAIT)
                cnt_rst_ff <= cnt_rst_ff + 1;
        end
    end

    assign osc_stable    = (cnt_osc_ff == OSC_WAIT);
    assign maincr_stable = (cnt_rst_ff >= MAINCR_WAIT);
    assign subcr_stable  = (cnt_rst_ff >= SUBCR_WAIT);
endmodule : smc_far_model

/* tb.sv */
// Self-checking testbench for the standby mode controller
`timescale 1ns/1ps
module tb;
    logic clk_sys, rst_b, sleep_wr, stop_wr, watch_wr, pin_sel, ext_irq, ie, busy, nvr;
    logic [1:0]  monitor, mask, acc_lvl;
    logic [7:0]  irq_pending;
    logic [15:0] irq_level;
    logic maincr_stable, subcr_stable, osc_stable;
    logic sleep_request, stop_request, watch_request, cpu_clk_en, wdt_clk_en, periph_clk_en;
    logic main_osc_en, hw_wdt_run, pin_hold, pin_float, force_maincr, restore_clk_mode;
    logic instr_suspended, irq_service, in_standby, subcr_osc_en;
    logic [1:0] saved_clk_mode;
    int err_total = 0;
    int n_tests   = 0;

    standby_mode_controller i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .sleep_request_wr(sleep_wr), .stop_request_wr(stop_wr), .watch_request_wr(watch_wr),
        .pin_hold_select(pin_sel), .clock_mode_monitor(monitor), .irq_pending(irq_pending),
        .irq_level(irq_level), .ext_irq(ext_irq), .interrupt_enable_flag(ie),
        .interrupt_level_mask(mask), .accepted_irq_level(acc_lvl), .instr_busy(busy),
        .nvr_wdt_standby_en(nvr), .maincr_stable(maincr_stable), .subcr_stable(subcr_stable),
        .osc_stable(osc_stable), .sleep_request(sleep_request), .stop_request(stop_request),
        .watch_request(watch_request), .cpu_clk_en(cpu_clk_en), .wdt_clk_en(wdt_clk_en),
        .periph_clk_en(periph_clk_en), .main_osc_en(main_osc_en),
        .subcr_osc_en(subcr_osc_en),
        .hw_wdt_run(hw_wdt_run), .pin_hold(pin_hold), .pin_float(pin_float),
        .force_maincr(force_maincr), .restore_clk_mode(restore_clk_mode),
        .saved_clk_mode(saved_clk_mode), .instr_suspended(instr_suspended),
        .irq_service(irq_service), .in_standby(in_standby));

    smc_far_model i_far (.clk_sys(clk_sys), .rst_b(rst_b), .main_osc_en(main_osc_en),
        .maincr_stable(maincr_stable), .subcr_stable(subcr_stable), .osc_stable(osc_stable));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : chk

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic wait_run;
        for (int i = 0; i < 200 && cpu_clk_en !== 1'b1; i++)
            @(negedge clk_sys);
        chk("cpu_clk_en", cpu_clk_en, 1'b1);
    endtask : wait_run

    // Request pulse, then in_standby exactly after the fourth edge
    task automatic enter(input int kind, input logic exp_in);
        repeat (3) @(negedge clk_sys);
        sleep_wr = (kind == 0);
        stop_wr  = (kind == 1);
        watch_wr = (kind == 2);
        @(negedge clk_sys);
        {sleep_wr, stop_wr, watch_wr} = 3'h0;
        repeat (2) @(negedge clk_sys);
        chk("in_standby early", in_standby, 1'b0);
        @(negedge clk_sys);
        chk("in_standby", in_standby, exp_in);
    endtask : enter

    task automatic wake(input logic exp_srv);
        for (int i = 0; i < 200 && in_standby !== 1'b0; i++)
            @(negedge clk_sys);
        chk("in_standby wake", in_standby, 1'b0);
        chk("restore_clk_mode", restore_clk_mode, 1'b1);
        chk("irq_service", irq_service, exp_srv);
        chk("cpu_clk_en", cpu_clk_en, 1'b1);
        chk("requests clear", sleep_request | stop_request | watch_request, 1'b0);
    endtask : wake

    initial begin
        #40000;
        err_total++;
        $display("Watchdog expired");
        final_report();
    end

    initial begin
        {rst_b, sleep_wr, stop_wr, watch_wr, pin_sel, ext_irq, ie, busy} = 8'h00;
        nvr = 1'b1;
        monitor = 2'h2;
        mask = 2'h3;
        acc_lvl = 2'h1;
        irq_pending = 8'h00;
        irq_level = 16'h0003;
        repeat (10) @(negedge clk_sys);
        chk("force_maincr", force_maincr, 1'b1);
        chk("cpu_clk_en rst", cpu_clk_en, 1'b0);
        chk("saved hi", saved_clk_mode[1], 1'b1);
        chk("saved lo", saved_clk_mode[0], 1'b0);
        rst_b = 1'b1;
        wait_run();
        @(negedge clk_sys);
        chk("force_maincr run", force_maincr, 1'b0);
        $display("test reset done");
        busy = 1'b1;
        enter(0, 1'b1);
        chk("cpu_clk_en", cpu_clk_en, 1'b0);
        chk("wdt_clk_en", wdt_clk_en, 1'b0);
        chk("periph_clk_en", periph_clk_en, 1'b1);
        chk("hw_wdt_run", hw_wdt_run, 1'b1);
        chk("subcr_osc_en", subcr_osc_en, 1'b1);
        chk("instr_suspended", instr_suspended, 1'b1);
        chk("sleep_request", sleep_request, 1'b1);
        busy = 1'b0;
        irq_pending = 8'h01;
        wake(1'b0);
        irq_pending = 8'h00;
        $display("test sleep done");
        pin_sel = 1'b1;
        ie = 1'b1;
        nvr = 1'b0;
        enter(1, 1'b1);
        chk("hw_wdt_run stop", hw_wdt_run, 1'b0);
        chk("subcr_osc_en stop", subcr_osc_en, 1'b0);
        chk("pin_float", pin_float, 1'b1);
        chk("pin_hold", pin_hold, 1'b0);
        chk("main_osc_en", main_osc_en, 1'b0);
        irq_pending = 8'h01;
        repeat (10) @(negedge clk_sys);
        chk("stop kept", in_standby, 1'b1);
        ext_irq = 1'b1;
        wake(1'b1);
        {ext_irq, irq_pending} = 9'h000;
        $display("test stop done");
        pin_sel = 1'b0;
        for (int m = 0; m < 4; m++) begin
            monitor = m[1:0];
            enter(2, 1'b1);
            chk("main_osc_en", main_osc_en, monitor[1]);
            chk("pin_hold", pin_hold, 1'b1);
            ext_irq = 1'b1;
            wake(1'b1);
            ext_irq = 1'b0;
            chk("saved hi", saved_clk_mode[1], monitor[1]);
            chk("saved lo", saved_clk_mode[0], monitor[0]);
        end
        $display("test watch done");
        ie = 1'b0;
        irq_pending = 8'h01;
        enter(0, 1'b0);
        chk("sleep_request", sleep_request, 1'b0);
        irq_pending = 8'h00;
        repeat (10) @(negedge clk_sys);
        chk("no late entry", in_standby, 1'b0);
        $display("test suppress done");
        monitor = 2'h3;
        enter(1, 1'b1);
        rst_b = 1'b0;
        @(negedge clk_sys);
        chk("force_maincr", force_maincr, 1'b1);
        chk("in_standby rst", in_standby, 1'b0);
        chk("stop_request", stop_request, 1'b0);
        chk("saved lo rst", saved_clk_mode[0], 1'b0);
        rst_b = 1'b1;
        wait_run();
        $display("test reset wake done");
        final_report();
    end
endmodule : tb
